/* hw/opp_programmer.sv */
// Programmer that writes and verifies the OTP array of the device.
// Assumes an image source that answers img_addr with img_data one cycle
// later, and a device already strapped into PROM mode.
`timescale 1ns/1ns
`default_nettype none
module opp_programmer import opp_pkg::*; #(
  parameter int PULSE1_CYC = PULSE_ALG1_CYC,
  parameter int PULSE2_CYC = PULSE_ALG2_CYC,
  parameter logic [14:0] LAST_ADDR = ADDR_LAST
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic alg_two,
  input wire logic size_32k,
  output logic [15:0] img_addr,
  input wire logic [7:0] img_data,
  input wire logic [7:0] data_in,
  output opp_pins_t pins,
  output opp_status_t status
);

  // ----------------------------------------------------------------
  // Reset release and pin synchroniser
  // ----------------------------------------------------------------
  logic rst_s1_q, rst_n;
  logic [7:0] din_s1_q, din_s2_q;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      din_s1_q <= 8'h00;
      din_s2_q <= 8'h00;
    end else begin
      din_s1_q <= data_in;
      din_s2_q <= din_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE, ST_SETUP, ST_PULSE, ST_RDSET, ST_CMP, ST_OVER, ST_NEXT,
    ST_FSET, ST_FCMP, ST_DONE
  } opp_state_t;

  opp_state_t st_q, st_d;
  logic [14:0] addr_q;
  logic [7:0] want_q;
  logic [4:0] tries_q;
  logic [3:0] wait_q;
  logic alg_q, big_q, vpp_q, fail_q, done_q, final_q;
  logic [14:0] fail_addr_q;
  logic [23:0] pulse_len;
  logic pulse_load, pulse_on;

  localparam logic [23:0] P1 = 24'(PULSE1_CYC);
  localparam logic [23:0] P2 = 24'(PULSE2_CYC);
  localparam logic [3:0] SETUP_W = 4'(SETUP_CYC);
  localparam logic [3:0] READ_W = 4'(READ_CYC);
  localparam logic [4:0] TRY_MAX = 5'(MAX_TRIES);

  wire [14:0] addr_first = big_q ? ADDR_FIRST_32K : ADDR_FIRST_16K;
  wire fill_zone = !big_q && (addr_q <= ADDR_FILL_LAST);
  // 16K image: CPU address = programming address + 8000h
  wire [15:0] cpu_addr = big_q ? {1'b1, addr_q}
                       : CPU_BASE_16K + {2'b00, addr_q[13:0]};
  wire wait_done = (wait_q == 4'h0);
  wire match = (din_s2_q == want_q);
  wire last_addr = (addr_q == LAST_ADDR);
  wire [23:0] over_len = 24'(OVER_FACTOR) * 24'(tries_q) * P1;

  assign img_addr = cpu_addr;

  opp_pulse_timer #(.W(24)) u_timer (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .load(pulse_load),
    .cycles(pulse_len),
    .active(pulse_on)
  );

  always_comb begin
    st_d = st_q;
    pulse_load = 1'b0;
    pulse_len = alg_q ? P2 : P1;
    unique case (st_q)
      ST_IDLE: if (start) st_d = ST_SETUP;
      ST_SETUP: if (wait_done) begin
        st_d = ST_PULSE;
        pulse_load = 1'b1;
      end
      ST_PULSE: if (!pulse_on && !pulse_load) st_d = ST_RDSET;
      ST_RDSET: if (wait_done) st_d = ST_CMP;
      ST_CMP: begin
        if (match) begin
          if (alg_q) begin
            st_d = ST_NEXT;
          end else begin
            st_d = ST_OVER;
            pulse_load = 1'b1;
            pulse_len = over_len;
          end
        end else if (tries_q >= TRY_MAX) begin
          st_d = ST_NEXT;
        end else begin
          st_d = ST_PULSE;
          pulse_load = 1'b1;
        end
      end
      ST_OVER: if (!pulse_on && !pulse_load) st_d = ST_NEXT;
      ST_NEXT: st_d = last_addr ? ST_FSET : ST_SETUP;
      ST_FSET: if (wait_done) st_d = ST_FCMP;
      ST_FCMP: st_d = last_addr ? ST_DONE : ST_FSET;
      ST_DONE: if (start) st_d = ST_SETUP;
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // Datapath registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_q <= 15'h0000;
      want_q <= 8'h00;
      tries_q <= 5'h00;
      wait_q <= 4'h0;
      alg_q <= 1'b0;
      big_q <= 1'b0;
      vpp_q <= 1'b0;
      final_q <= 1'b0;
    end else begin
      if (!wait_done) wait_q <= wait_q - 4'h1;
      if ((st_q == ST_IDLE || st_q == ST_DONE) && start) begin
        alg_q <= alg_two;
        big_q <= size_32k;
        addr_q <= size_32k ? ADDR_FIRST_32K : ADDR_FIRST_16K;
        vpp_q <= 1'b1;
        final_q <= 1'b0;
        tries_q <= 5'h00;
        wait_q <= SETUP_W;
      end
      // Image byte settles one cycle after img_addr moves
      if (st_q == ST_SETUP || st_q == ST_FSET) begin
        want_q <= fill_zone ? BLANK_BYTE : img_data;
      end
      if (pulse_load && st_d == ST_PULSE) tries_q <= tries_q + 5'h01;
      if (st_q == ST_PULSE && st_d == ST_RDSET) wait_q <= READ_W;
      if (st_q == ST_NEXT) begin
        tries_q <= 5'h00;
        if (last_addr) begin
          addr_q <= addr_first;
          vpp_q <= 1'b0;
          final_q <= 1'b1;
          wait_q <= READ_W;
        end else begin
          addr_q <= addr_q + 15'h0001;
          wait_q <= SETUP_W;
        end
      end
      if (st_q == ST_FCMP && !last_addr) begin
        addr_q <= addr_q + 15'h0001;
        wait_q <= READ_W;
      end
      if (st_q == ST_FCMP && last_addr) vpp_q <= 1'b0;
    end
  end

  // Failure tracking; first failing address is kept
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fail_q <= 1'b0;
      done_q <= 1'b0;
      fail_addr_q <= 15'h0000;
    end else begin
      if ((st_q == ST_IDLE || st_q == ST_DONE) && start) begin
        fail_q <= 1'b0;
        done_q <= 1'b0;
      end
      if (((st_q == ST_CMP && tries_q >= TRY_MAX) || st_q == ST_FCMP)
          && !match && !fail_q) begin
        fail_q <= 1'b1;
        fail_addr_q <= addr_q;
      end
      if (st_q == ST_FCMP && last_addr) done_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  wire reading = (st_q == ST_RDSET || st_q == ST_CMP
               || st_q == ST_FSET || st_q == ST_FCMP);
  wire writing = (st_q == ST_SETUP || st_q == ST_PULSE || st_q == ST_OVER);

  // Drive off while the device drives, so the bus never contends
  assign pins.addr = addr_q;
  assign pins.data_out = want_q;
  assign pins.data_oe = writing;
  assign pins.sel_b = !(pulse_on || reading);
  assign pins.oe_b = !reading;
  assign pins.vpp_high = vpp_q && !final_q;
  assign pins.addr_nine_high = 1'b0;
  assign status.busy = (st_q != ST_IDLE && st_q != ST_DONE);
  assign status.done = done_q;
  assign status.fail = fail_q;
  assign status.fail_addr = fail_addr_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  pulse_no_read_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    pulse_on |-> pins.oe_b && pins.data_oe)
    else $error("output drive during write pulse");
  try_limit_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    tries_q <= TRY_MAX)
    else $error("attempt count beyond limit");
  no_sig_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !pins.addr_nine_high)
    else $error("identifier voltage on address line nine");
  alg2_no_over_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    alg_q |-> st_q != ST_OVER)
    else $error("extra pulse in algorithm two");
  fill_ff_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (st_q == ST_PULSE && fill_zone) |-> want_q == BLANK_BYTE)
    else $error("unused area not FF");
  range_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (status.busy && !big_q) |-> addr_q >= ADDR_FIRST_16K)
    else $error("16K write below array");
  retry_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (st_q == ST_CMP && !match && tries_q < TRY_MAX) |=> pulse_on)
    else $error("no retry pulse on mismatch");
  step_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (st_q == ST_NEXT && !last_addr) |=> addr_q == $past(addr_q) + 15'h0001)
    else $error("address not stepped");
  final_low_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    (st_q == ST_FCMP) |-> !pins.vpp_high)
    else $error("final verify at program voltage");

endmodule : opp_programmer
`default_nettype wire

/* hw/opp_pulse_timer.sv */
// Down-counter that times one write pulse of a given cycle length.
// Assumes load is a one-cycle pulse from the same clock domain.
`timescale 1ns/1ns
`default_nettype none
module opp_pulse_timer import opp_pkg::*; #(
  parameter int W = 24
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [W-1:0] cycles,
  output logic active
);

  logic [W-1:0] cnt_q;

  assign active = (cnt_q != '0);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= cycles;
    end else if (active) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

endmodule : opp_pulse_timer
`default_nettype wire

/* include/opp_pkg.sv */
// Package for the one-time PROM programmer controller.
// Assumes a 10 MHz core clock; the device outside is in its PROM mode.
package opp_pkg;

  // ----------------------------------------------------------------
  // Clock and pulse timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 10000000;
  localparam int PULSE_ALG1_US = 1000;
  localparam int PULSE_ALG2_US = 100;
  localparam int PULSE_ALG1_CYC = (PULSE_ALG1_US * (CLK_HZ / 1000000));
  localparam int PULSE_ALG2_CYC = (PULSE_ALG2_US * (CLK_HZ / 1000000));
  localparam int OVER_FACTOR = 3;
  localparam int MAX_TRIES = 25;
  localparam int SETUP_CYC = 2;
  localparam int READ_CYC = 3;

  // ----------------------------------------------------------------
  // Address map of the device outside
  // ----------------------------------------------------------------
  localparam logic [14:0] ADDR_FIRST_32K = 15'h0000;
  localparam logic [14:0] ADDR_FIRST_16K = 15'h4000;
  localparam logic [14:0] ADDR_LAST = 15'h7FFF;
  localparam logic [14:0] ADDR_FILL_LAST = 15'h3FFF;
  localparam logic [15:0] CPU_BASE_16K = 16'hC000;
  localparam logic [7:0] BLANK_BYTE = 8'hFF;

  // ----------------------------------------------------------------
  // Pin groups
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [14:0] addr;
    logic [7:0] data_out;
    logic data_oe;
    logic sel_b;
    logic oe_b;
    logic vpp_high;
    logic addr_nine_high;
  } opp_pins_t;

  typedef struct packed {
    logic busy;
    logic done;
    logic fail;
    logic [14:0] fail_addr;
  } opp_status_t;

endpackage : opp_pkg

/* sim/opp_prom_model.sv */
// Model of the device in PROM mode: OTP array, pulse count, read drive.
// Assumes pins from the programmer on the same clock; erase = new part.
`timescale 1ns/1ns
`default_nettype none
module opp_prom_model import opp_pkg::*; (
  input wire logic core_clk,
  input wire logic prom_mode,
  input wire logic big,
  input wire logic erase,
  input wire logic [14:0] slow_addr,
  input wire logic [4:0] slow_cnt,
  input wire opp_pins_t pins,
  output logic [7:0] data_in
);
  // ----------------------------------------------------------------
  // Array and pin decode
  // ----------------------------------------------------------------
  logic [7:0] mem [0:32767];
  logic [7:0] last_q;
  logic [4:0] pcnt_q;
  logic [14:0] addr_q;
  logic wr_q;
  logic low_freq_osc_enable = 1'b0;
  wire wr = prom_mode & ~pins.sel_b & pins.data_oe & pins.vpp_high;
  wire rd = prom_mode & ~pins.sel_b & ~pins.oe_b & ~pins.data_oe;
  wire ok = big | pins.addr[14];
  wire [4:0] need = (pins.addr == slow_addr) ? slow_cnt : 5'h01;
  // Undriven bus: changes every cycle so a stale byte never matches
  assign data_in = rd ? mem[pins.addr] : ~last_q;
  // ----------------------------------------------------------------
  // Programming: a byte takes after need pulses
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    last_q <= data_in;
    wr_q <= wr;
    addr_q <= pins.addr;
    if (erase) begin
      for (int i = 0; i < 32768; i++) mem[i] = 8'hFF;
      pcnt_q = 5'h00;
    end
    if (pins.addr != addr_q) pcnt_q = 5'h00;
    if (wr_q && !wr) begin
      pcnt_q = pcnt_q + 5'h01;
      if (pcnt_q >= need && ok) mem[pins.addr] &= pins.data_out;
    end
  end
endmodule : opp_prom_model
`default_nettype wire

/* sim/test_opp_programmer.sv */
// Testbench for the OTP programmer against the device model.
// Assumes short pulses and a last address cut to 40FF to bound run time.
`timescale 1ns/1ns
`default_nettype none
module test_opp_programmer;
  import opp_pkg::*;
  localparam int P1 = 4;
  localparam int P2 = 2;
  localparam logic [14:0] LAST = 15'h40FF;
  localparam int N16 = 256;
  logic core_clk = 0, rst_b = 0, start = 0, alg_two = 0, size_32k = 0;
  logic erase = 1, oe_q = 1;
  logic [15:0] img_addr;
  logic [7:0] img_data = 8'h00, data_in, key = 8'h00, lf = 8'h62;
  logic [14:0] slow_addr = 15'h4000, pa, ra;
  logic [4:0] slow_cnt = 5'h01;
  opp_pins_t pins;
  opp_status_t status;
  int n_errors = 0, comparisons = 0, len = 0, fin_rd = 0, n, k;
  int plen[$];
  logic [14:0] padr[$];
  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) img_data <= img_fn(img_addr);
  opp_programmer #(.PULSE1_CYC(P1), .PULSE2_CYC(P2),
    .LAST_ADDR(LAST)) i_dut (
    .core_clk(core_clk), .rst_b(rst_b), .start(start),
    .alg_two(alg_two), .size_32k(size_32k), .img_addr(img_addr),
    .img_data(img_data), .data_in(data_in), .pins(pins), .status(status));
  opp_prom_model i_model (.core_clk(core_clk), .prom_mode(1'b1),
    .big(size_32k), .erase(erase), .slow_addr(slow_addr),
    .slow_cnt(slow_cnt), .pins(pins), .data_in(data_in));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] img_fn(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ key;
  endfunction : img_fn
  function automatic logic [15:0] cpu_of(input logic [14:0] a);
    return size_32k ? {1'b1, a} : {2'b11, a[13:0]};
  endfunction : cpu_of
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  task automatic check(input logic [31:0] got, exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask : check
  task automatic cyc(input int c);
    repeat (c) @(posedge core_clk);
  endtask : cyc
  task automatic reset_dut(input int c);
    rst_b <= 1'b0;
    erase <= 1'b1;
    cyc(c);
    check({pins.sel_b, pins.oe_b, pins.data_oe, pins.vpp_high,
      status.done, status.fail}, 6'b110000, "idle");
    rst_b <= 1'b1;
    erase <= 1'b0;
    cyc(3);
  endtask : reset_dut
  task automatic go(input logic alg, big);
    plen = {};
    padr = {};
    fin_rd = 0;
    alg_two <= alg;
    size_32k <= big;
    start <= 1'b1;
    cyc(1);
    start <= 1'b0;
    cyc(1);
    #1;
    check({status.busy, status.done, status.fail}, 3'b100, "start");
  endtask : go
  task automatic wait_q(input int c);
    for (int i = 0; i < 20000 && padr.size() < c; i++) cyc(1);
  endtask : wait_q
  task automatic wrap_up;
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up
  // ----------------------------------------------------------------
  // Pin monitor
  // ----------------------------------------------------------------
  always @(negedge core_clk) begin
    check(pins.addr_nine_high, 1'b0, "line nine");
    if (!pins.oe_b) check(pins.data_oe, 1'b0, "drive in read");
    // Final reads keep drive low; count each new address read
    if (!pins.oe_b && !pins.vpp_high && (oe_q || pins.addr != ra)) fin_rd++;
    oe_q = pins.oe_b;
    ra = pins.addr;
    if (!pins.sel_b && pins.data_oe) begin
      len++;
      pa = pins.addr;
      check(pins.data_out, img_fn(cpu_of(pa)), "data");
    end else if (len > 0) begin
      plen.push_back(len);
      padr.push_back(pa);
      len = 0;
    end
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    #(100 * 50000);
    n_errors++;
    wrap_up;
  end
  initial begin
    reset_dut(20);
    // Full 16K run, alg II, one byte that never takes
    lf = lfsr(lf);
    key = lf;
    lf = lfsr(lf);
    slow_addr <= {7'h40, lf};
    slow_cnt <= 5'd26;
    if (img_fn({8'hC0, lf}) == 8'hFF) key ^= 8'h01;
    go(1'b1, 1'b0);
    for (int i = 0; i < 20000 && status.done !== 1'b1; i++) cyc(1);
    check(status.done, 1'b1, "done");
    check(status.fail, 1'b1, "fail");
    check(status.fail_addr, {7'h40, lf}, "fail addr");
    check(padr.size(), N16 + 24, "pulses");
    check(padr[0], 15'h4000, "first");
    check(padr[$], LAST, "last");
    check(fin_rd, N16, "final reads");
    check(i_model.mem[LAST], img_fn(16'hC0FF), "array");
    n = 0;
    foreach (padr[i]) begin
      n += (padr[i] == {7'h40, lf});
      check(plen[i], P2, "width");
    end
    check(n, 25, "tries");
    $display("alg II full run finished");
    // Restart from done, alg I, slow byte at 4001
    erase <= 1'b1;
    lf = lfsr(lf);
    k = 2 + lf % 5;
    key = lf;
    if (img_fn(16'hC001) == 8'hFF) key ^= 8'h01;
    slow_addr <= 15'h4001;
    slow_cnt <= k[4:0];
    cyc(1);
    erase <= 1'b0;
    go(1'b0, 1'b0);
    start <= 1'b1;
    cyc(1);
    start <= 1'b0;
    wait_q(k + 5);
    reset_dut(2);
    for (int i = 0; i < k + 5; i++) begin
      n = (i == 1 || i == k + 4) ? 3 * P1 : (i == k + 2) ? 3 * k * P1 : P1;
      check(plen[i], n, "alg I width");
      n = (i < 2) ? 0 : (i < k + 3) ? 1 : 2;
      check(padr[i], 15'h4000 + n, "alg I addr");
    end
    $display("alg I abort finished");
    // 32K run starts at 0000, aborted in read-back after the third pulse
    slow_cnt <= 5'h01;
    go(1'b1, 1'b1);
    wait_q(3);
    check(padr[0], 15'h0000, "32K first");
    check(padr[2], 15'h0002, "32K step");
    cyc(1);
    reset_dut(1);
    $display("32K abort finished");
    wrap_up;
  end
endmodule : test_opp_programmer
`default_nettype wire
